/* File: verilog/mbs_slave.sv */
/*
 * Slave query interpreter for loopback, multiple-coil write and
 * multiple-register write. Takes CRC-checked query bytes from a framer
 * (RX_* with RX_END marking frame end) and hands back response bytes.
 * Assumes the framer computes and appends CRC and drops bad-CRC frames.
 */
`timescale 1ns/1ps
`include "mbs_map.svh"

module mbs_slave (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] SLAVE_ADDR,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	input wire logic RX_END,
	input wire logic TX_READY,
	output logic [7:0] TX_DATA,
	output logic TX_VALID,
	output logic TX_LAST,
	output logic [`MBS_TERM_COUNT-1:0] TERMINALS,
	output logic [31:0] FIRST_ACCEL_TIME,
	output logic WRITE_DONE
);
	import mbs_pkg::*;
	localparam int QN = `MBS_MAX_QUERY;

	// ==========================================
	// State
	typedef struct packed {
		mbs_state_t st;
		logic [4:0] cnt;
		logic [QN*8-1:0] q;
		logic [4:0] term;
		logic [31:0] accel;
		logic [63:0] resp;
		logic [3:0] rlen;
		logic go;
		logic done;
		logic [7:0] txd;
		logic txv;
		logic txl;
	} mbs_state_s_t;
	mbs_state_s_t s_r, s_nxt;

	logic [7:0] tx_data;
	logic tx_valid, tx_last, tx_busy, tx_ready;

	function automatic logic [7:0] qb(input logic [QN*8-1:0] q, input int i);
		qb = q[(QN-1-i)*8 +: 8];
	endfunction

	// ==========================================
	// Query decode
	logic [7:0] f_addr, f_fc, f_bc, f_exc;
	logic [15:0] f_w2, f_w4, f_end;
	logic [4:0] f_len;
	logic f_ok;
	wire logic [4:0] new_term;
	always_comb begin
		f_addr = qb(s_r.q, 0);
		f_fc = qb(s_r.q, 1);
		f_w2 = {qb(s_r.q, 2), qb(s_r.q, 3)};
		f_w4 = {qb(s_r.q, 4), qb(s_r.q, 5)};
		f_bc = qb(s_r.q, 6);
		f_end = f_w2 + f_w4 - 16'h0001;
		f_exc = 8'h00;
		f_len = 5'd0;
		case (f_fc)
			`MBS_FC_LOOPBACK: begin
				f_len = 5'd6;
				if (f_w2 != `MBS_ECHO_SUB) f_exc = `MBS_EX_NOT_FOUND;
			end
			`MBS_FC_WR_COILS: begin
				f_len = 5'(7 + 32'(f_bc));
				if (f_w4 == 16'h0000 || f_bc[0] || {8'h00, f_bc} < ((f_w4 + 16'h0007) >> 3))
					f_exc = `MBS_EX_BAD_FORMAT;
				else if (f_end > `MBS_COIL_LAST_ADDR)
					f_exc = `MBS_EX_RANGE;
			end
			`MBS_FC_WR_REGS: begin
				f_len = 5'(7 + 32'(f_bc));
				if (f_w4 == 16'h0000 || {8'h00, f_bc} != (f_w4 << 1))
					f_exc = `MBS_EX_BAD_FORMAT;
				else if (f_w2 < `MBS_ACCEL_HI_ADDR || f_end > `MBS_ACCEL_LO_ADDR)
					f_exc = `MBS_EX_RANGE;
			end
			default: f_exc = `MBS_EX_BAD_FUNC;
		endcase
		// Length judged after fields, so a field fault reports its own code
		f_ok = (s_r.cnt == f_len) && (f_len != 5'd0);
	end

	// ==========================================
	// Terminal coils
	// Coil at line address a is bit (a-start)%8 of data byte (a-start)/8
	for (genvar gi = 0; gi < `MBS_TERM_COUNT; gi++) begin : g_term
		logic [15:0] c_addr;
		logic [15:0] c_off;
		logic [7:0] c_byte;
		logic c_hit;
		assign c_addr = `MBS_COIL_TERM_ADDR + 16'(gi);
		assign c_off = c_addr - f_w2;
		assign c_hit = (c_addr >= f_w2) && (c_addr <= f_end);
		// Hits lie within ten coils of the start: one offset bit picks the byte
		assign c_byte = c_off[3] ? qb(s_r.q, 8) : qb(s_r.q, 7);
		assign new_term[gi] = c_hit ? c_byte[c_off[2:0]] : s_r.term[gi];
	end

	// ==========================================
	// Sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.go = 1'b0;
		s_nxt.done = 1'b0;
		case (s_r.st)
			MBS_IDLE, MBS_RECV: begin
				if (RX_VALID) begin
					// Overlong frames keep counting, saturating at 31, so the length check refuses them
					if (s_r.cnt < 5'(QN)) s_nxt.q[(QN-1-32'(s_r.cnt))*8 +: 8] = RX_DATA;
					if (s_r.cnt != 5'h1F) s_nxt.cnt = s_r.cnt + 5'd1;
					s_nxt.st = MBS_RECV;
				end
				if (RX_END) s_nxt.st = MBS_EXEC;
			end
			MBS_EXEC: begin
				// Foreign and broadcast frames fall through and clear the count
				s_nxt.st = MBS_DROP;
				if (f_addr == SLAVE_ADDR && f_addr != `MBS_BROADCAST) begin
					s_nxt.st = MBS_SEND;
					s_nxt.go = 1'b1;
					s_nxt.rlen = 4'd6;
					s_nxt.resp = s_r.q[QN*8-1 -: 64];
					if (f_exc == 8'h00 && !f_ok) begin
						s_nxt.resp = {f_addr, f_fc | `MBS_FC_EXC_BIT, `MBS_EX_BAD_FORMAT, 40'h0};
						s_nxt.rlen = 4'd3;
					end else if (f_exc != 8'h00) begin
						s_nxt.resp = {f_addr, f_fc | `MBS_FC_EXC_BIT, f_exc, 40'h0};
						s_nxt.rlen = 4'd3;
					end else if (f_fc == `MBS_FC_WR_COILS) begin
						s_nxt.term = new_term;
						s_nxt.done = 1'b1;
					end else if (f_fc == `MBS_FC_WR_REGS) begin
						// High register carries upper half of the 32-bit value
						for (int r = 0; r < 2; r++) begin
							if (f_w2 + 16'(r) <= f_end && f_w2 + 16'(r) >= `MBS_ACCEL_HI_ADDR) begin
								if (f_w2 + 16'(r) == `MBS_ACCEL_HI_ADDR)
									s_nxt.accel[31:16] = {qb(s_r.q, 7 + 2*r), qb(s_r.q, 8 + 2*r)};
								else
									s_nxt.accel[15:0] = {qb(s_r.q, 7 + 2*r), qb(s_r.q, 8 + 2*r)};
							end
						end
						s_nxt.done = 1'b1;
					end
				end
			end
			// Query bytes arriving during the reply are ignored
			MBS_SEND: if (!s_r.go && !tx_busy) s_nxt.st = MBS_DROP;
			MBS_DROP: begin
				s_nxt.cnt = 5'd0;
				s_nxt.st = MBS_IDLE;
			end
			default: s_nxt.st = MBS_IDLE;
		endcase
		// Registered byte stage toward the framer
		if (!s_r.txv || TX_READY) begin
			s_nxt.txv = tx_valid;
			s_nxt.txd = tx_data;
			s_nxt.txl = tx_last;
		end
	end
	assign tx_ready = !s_r.txv || TX_READY;

	// ==========================================
	// Registers
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_r <= '0;
			s_r.accel <= `MBS_ACCEL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================
	// Reply sender
	// Eight-byte buffer covers the longest reply before CRC
	mbs_resp_tx #(.DEPTH(8)) u_tx (
		.clk(CLK),
		.reset_n(RESET_N),
		.start(s_r.go),
		.len(s_r.rlen),
		.frame(s_r.resp),
		.ready(tx_ready),
		.data(tx_data),
		.valid(tx_valid),
		.last(tx_last),
		.busy(tx_busy)
	);

	// ==========================================
	// Outputs
	assign TX_DATA = s_r.txd;
	assign TX_VALID = s_r.txv;
	assign TX_LAST = s_r.txl;
	assign TERMINALS = s_r.term;
	assign FIRST_ACCEL_TIME = s_r.accel;
	assign WRITE_DONE = s_r.done;
endmodule

/* File: verilog/mbs_map.svh */
/*
 * Byte-level constants of the slave query interpreter: function codes,
 * exception codes and coil and register positions.
 * Assumes the includer is a SystemVerilog compilation unit.
 */
`ifndef MBS_MAP_SVH
`define MBS_MAP_SVH

// ==========================================
// Function codes
`define MBS_FC_LOOPBACK 8'h08
`define MBS_FC_WR_COILS 8'h0F
`define MBS_FC_WR_REGS 8'h10
`define MBS_FC_EXC_BIT 8'h80

// ==========================================
// Exception codes
`define MBS_EX_BAD_FUNC 8'h01
`define MBS_EX_NOT_FOUND 8'h02
`define MBS_EX_BAD_FORMAT 8'h03
`define MBS_EX_RANGE 8'h21
`define MBS_EX_NOT_ALLOWED 8'h22

// ==========================================
// Addressing
`define MBS_BROADCAST 8'h00
`define MBS_ECHO_SUB 16'h0000
`define MBS_COIL_TERM_ADDR 16'h0006
`define MBS_COIL_LAST_ADDR 16'h001E
`define MBS_TERM_COUNT 5
`define MBS_ACCEL_HI_ADDR 16'h1013
`define MBS_ACCEL_LO_ADDR 16'h1014
`define MBS_ACCEL_RESET 32'h0000_0000
`define MBS_MAX_QUERY 16

`endif

/* File: verilog/mbs_pkg.sv */
/*
 * Types of the slave query interpreter.
 * Assumes mbs_map.svh sits on the include path.
 */
package mbs_pkg;
	typedef enum logic [2:0] {
		MBS_IDLE = 3'b000,
		MBS_RECV = 3'b001,
		MBS_EXEC = 3'b010,
		MBS_SEND = 3'b011,
		MBS_DROP = 3'b100
	} mbs_state_t;
	typedef logic [7:0] mbs_byte_t;
endpackage

/* File: verilog/mbs_resp_tx.sv */
/*
 * Response byte sender: walks a prepared frame buffer one byte per
 * handshake. Assumes the framer appends CRC after the last byte.
 */
`timescale 1ns/1ps
module mbs_resp_tx #(
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [3:0] len,
	input wire logic [DEPTH*8-1:0] frame,
	input wire logic ready,
	output logic [7:0] data,
	output logic valid,
	output logic last,
	output logic busy
);
	import mbs_pkg::*;
	typedef struct packed {
		logic [3:0] idx;
		logic [3:0] len;
		logic busy;
		logic [DEPTH*8-1:0] buf_;
	} mbs_tx_t;
	mbs_tx_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (start && !s_r.busy) begin
			s_nxt.busy = 1'b1;
			s_nxt.idx = 4'h0;
			s_nxt.len = len;
			s_nxt.buf_ = frame;
		end else if (s_r.busy && ready) begin
			if (s_r.idx == s_r.len - 4'h1) begin
				s_nxt.busy = 1'b0;
			end
			s_nxt.idx = s_r.idx + 4'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign data = s_r.buf_[(DEPTH-1-32'(s_r.idx))*8 +: 8];
	assign valid = s_r.busy;
	assign last = s_r.busy && (s_r.idx == s_r.len - 4'h1);
	assign busy = s_r.busy;
endmodule

/* File: dv/mbs_slave_properties.sv */
/*
 * Port checker of the slave query interpreter.
 * Assumes binding into mbs_slave, one clock domain.
 */
`timescale 1ns/1ps
`include "mbs_map.svh"
module mbs_slave_properties (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic RX_END,
	input wire logic TX_READY,
	input wire logic [7:0] TX_DATA,
	input wire logic TX_VALID,
	input wire logic TX_LAST,
	input wire logic [`MBS_TERM_COUNT-1:0] TERMINALS,
	input wire logic [31:0] FIRST_ACCEL_TIME,
	input wire logic WRITE_DONE
);
	// ====
	// Reply byte index
	logic [3:0] idx_r;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) idx_r <= 4'h0;
		else if (TX_VALID && TX_READY) idx_r <= TX_LAST ? 4'h0 : idx_r + 4'h1;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// ====
	// Properties
	chk_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
		else $error("reply byte moved before taken");
	chk_reply_len: assert property (TX_VALID && TX_LAST |-> idx_r == 4'h2 || idx_r == 4'h5)
		else $error("reply length wrong");
	chk_last_drop: assert property (TX_VALID && TX_READY && TX_LAST |=> !TX_VALID)
		else $error("reply runs past last byte");
	chk_wd_pulse: assert property (WRITE_DONE |=> !WRITE_DONE)
		else $error("write strobe too long");
	chk_wd_cause: assert property (WRITE_DONE |-> $past(RX_END, 2))
		else $error("write without frame end");
	chk_write_first: assert property (WRITE_DONE |-> !TX_VALID)
		else $error("reply before write applied");
	chk_term_cause: assert property ($changed(TERMINALS) |-> WRITE_DONE)
		else $error("terminals moved without write");
	chk_accel_cause: assert property ($changed(FIRST_ACCEL_TIME) |-> WRITE_DONE)
		else $error("accel time moved without write");
endmodule
bind mbs_slave mbs_slave_properties u_chk (.CLK(CLK), .RESET_N(RESET_N), .RX_END(RX_END),
	.TX_READY(TX_READY), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_LAST(TX_LAST),
	.TERMINALS(TERMINALS), .FIRST_ACCEL_TIME(FIRST_ACCEL_TIME), .WRITE_DONE(WRITE_DONE));

/* File: dv/mbs_master_model.sv */
/*
 * Bus master model: feeds query bytes and stalls the reply side.
 * Assumes the caller waits for each reply before the next query.
 */
`timescale 1ns/1ps
module mbs_master_model (
	input wire logic clk,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_end,
	output logic tx_ready
);
	int sd = 47;
	initial begin
		rx_data = 8'hFF;
		rx_valid = 1'b0;
		rx_end = 1'b0;
	end
	// Random stalls exercise the hold of stalled reply bytes
	always @(posedge clk) tx_ready <= #1 ($random(sd) % 3) != 0;
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge clk);
			#1 rx_data = q[i];
			rx_valid = 1'b1;
		end
		@(posedge clk);
		// Stale data is inverted so it never looks valid
		#1 rx_data = ~rx_data;
		rx_valid = 1'b0;
		rx_end = 1'b1;
		@(posedge clk);
		#1 rx_end = 1'b0;
	endtask
endmodule

/* File: dv/mbs_slave_tb.sv */
/*
 * Self-checking bench of the slave query interpreter.
 * Assumes the framer strips CRC; replies are compared without it.
 */
`timescale 1ns/1ps
module mbs_slave_tb;
	import mbs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] rx_data, tx_data;
	logic rx_valid, rx_end, tx_ready, tx_valid, tx_last, wr_done;
	logic [4:0] terms;
	logic [31:0] accel, d;
	int n_errors = 0;
	int comparisons = 0;
	int n_wd = 0;
	int seed = 47;
	mbs_byte_t exq[$];
	mbs_byte_t e_b;
	always #5 clk = ~clk;
	mbs_slave DUT (.CLK(clk), .RESET_N(rst_n), .SLAVE_ADDR(8'h08), .RX_DATA(rx_data), .RX_VALID(rx_valid),
		.RX_END(rx_end), .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last),
		.TERMINALS(terms), .FIRST_ACCEL_TIME(accel), .WRITE_DONE(wr_done));
	mbs_master_model m (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .tx_ready(tx_ready));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		if (n_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ====
	// Reply monitor
	always @(posedge clk) begin
		if (wr_done === 1'b1) n_wd++;
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (exq.size() == 0) check("tx_data", tx_data, 32'h100);
			else begin
				e_b = exq.pop_front();
				check("tx_data", tx_data, e_b);
				check("tx_last", tx_last, exq.size() == 0);
			end
		end
	end
	task automatic run(input logic [127:0] q, input int nq, input logic [63:0] r, input int nr);
		logic [7:0] b[$];
		int i;
		for (i = nr - 1; i >= 0; i--) exq.push_back(r[i*8+:8]);
		for (i = nq - 1; i >= 0; i--) b.push_back(q[i*8+:8]);
		m.send(b);
		for (i = 0; i < 300 && exq.size() > 0; i++) @(posedge clk);
		if (exq.size() > 0) begin
			check("reply wait", 0, 1);
			end_sim();
		end
		repeat (12) @(posedge clk);
	endtask
	// ====
	// Scenarios
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_n = 1'b1;
		d = $random(seed);
		run({32'h08080000, d[15:0]}, 6, {32'h08080000, d[15:0]}, 6);
		run({32'h08080001, d[15:0]}, 6, 24'h088802, 3);
		run(72'h000F000600050217_00, 9, 0, 0);
		check("terminals", terms, 0);
		check("write strobes", n_wd, 0);
		run(72'h080F000600050217_00, 9, 48'h080F00060005, 6);
		check("terminals", terms, 5'h17);
		check("write strobes", n_wd, 1);
		run(72'h080F000700020202_00, 9, 48'h080F00070002, 6);
		check("terminals", terms, 5'h15);
		run(64'h080F000600050117, 8, 24'h088F03, 3);
		check("write strobes", n_wd, 2);
		run({56'h08101013000204, d}, 11, 48'h081010130002, 6);
		check("accel", accel, d);
		check("write strobes", n_wd, 3);
		run({56'h08101013000202, ~d}, 11, 24'h089003, 3);
		run(72'h08101015000102_1234, 9, 24'h089021, 3);
		check("accel", accel, d);
		check("write strobes", n_wd, 3);
		run(48'h080300000001, 6, 24'h088301, 3);
		end_sim();
	end
endmodule
